/* File: rtl/smc_pkg.sv */
package smc_pkg;
  localparam int CURVE_AW = 11;
  localparam int CURVE_DW = 8;
  localparam int CURVE_DEPTH = 2048;
  localparam int CURVE_POINTS = 128;
  localparam int IRQ_LINES = 8;
  localparam int FRAME_W = 8;
  localparam int LED_W = 8;
  localparam int CFG_W = 8;
  localparam int PROBE_ID_W = 4;
  localparam int TRACK_W = 4;
  // Interrupt line numbers, 0 has the highest priority.
  localparam logic [2:0] IRQ_TIMER = 3'h0;
  localparam logic [2:0] IRQ_FOOT = 3'h1;
  localparam logic [2:0] IRQ_KEYB = 3'h2;
  localparam logic [2:0] IRQ_PROBE_OPEN = 3'h3;
  localparam logic [2:0] IRQ_PROBE_CLOSE = 3'h4;
  localparam logic [2:0] IRQ_TRACK = 3'h6;
  localparam logic [2:0] IRQ_FREEZE = 3'h7;
  // Curve buffer address: bit 0 picks gain/filter, bits 7:1 the point, bit 8 the motion set.
  localparam int ADDR_SEL_POS = 0;
  localparam int ADDR_PT_POS = 1;
  localparam int ADDR_MOTION_POS = 8;
  // Real time clock ticks at 32768 Hz; the interval timer runs at 4 Hz.
  localparam int RTC_HZ = 32768;
  localparam int TIMER_HZ = 4;
  localparam int RTC_DIV = RTC_HZ / TIMER_HZ;
  localparam int SAMPLE_CYCLES = 4;
  typedef enum logic [3:0] {
    OP_CURVE_WR = 4'h0,
    OP_CURVE_RD = 4'h1,
    OP_FLAG_SET = 4'h2,
    OP_FLAG_CLR = 4'h3,
    OP_FRAMES = 4'h4,
    OP_LEDS = 4'h5,
    OP_KICK = 4'h6,
    OP_RELAY = 4'h7,
    OP_CFG_RD = 4'h8,
    OP_PROBE_RD = 4'h9
  } smc_op_t;
endpackage

/* File: rtl/smc_if.sv */
`timescale 1ns/1ps
interface smc_if;
  logic cmd_valid;
  smc_pkg::smc_op_t cmd_op;
  logic [10:0] cmd_addr;
  logic [7:0] cmd_data;
  logic rsp_valid;
  logic rsp_err;
  logic [7:0] rsp_data;
  logic irq;
  logic [2:0] irq_vec;
  logic irq_ack;
  logic flag;
  logic frozen;
  modport dev (
    input cmd_valid, cmd_op, cmd_addr, cmd_data, irq_ack,
    output rsp_valid, rsp_err, rsp_data, irq, irq_vec, flag, frozen
  );
  modport host (
    output cmd_valid, cmd_op, cmd_addr, cmd_data, irq_ack,
    input rsp_valid, rsp_err, rsp_data, irq, irq_vec, flag, frozen
  );
endinterface

/* File: rtl/smc_master_dev.sv */
// Overview of operation
// (R01) Eight prioritised interrupt lines, line 0 highest.
// (R02) Any trackball direction rising raises line 6.
// (R03) Probe connect/disconnect interrupt; probe ID readable.
// (R04) Shared flag marks data available/busy/done.
// (R05) 2K by 8 buffer holds both curves.
// (R06) Each pulse reads 128 points per curve.
// (R07) Curves interleave on one path, then split.
// (R08) Range counter reads; controller address muxed in.
// (R09) Controller writes only while frozen.
// (R10) Motion mode reads separate curve set.
// (R11) Controller may read buffer while frozen.
// (R12) Controller recomputes curves after parameter interrupt.
// (R13) Codes span full range: gain, filter.
// (R14) Controller loads frame count; device counts frames.
// (R15) Monitor and print shutter timed by vsync.
// (R16) One LED watchdog, others software status.
// (R17) Configuration switch readable by software.
// (R18) Relay output drives multiformat camera shutter.
// (R19) Alternate samples latched into separate holding registers.
// (R20) Interval timer is divided 4 Hz tick.
`timescale 1ns/1ps
module smc_master_dev #(
  parameter int RTC_DIV = smc_pkg::RTC_DIV,
  parameter int SAMPLE_CYCLES = smc_pkg::SAMPLE_CYCLES
) (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // System controller side.
  smc_if.dev bus,
  // Interrupt sources and status.
  input wire logic i_rtc_tick,
  input wire logic i_footswitch,
  input wire logic i_keyboard,
  input wire logic [smc_pkg::TRACK_W-1:0] i_trackball,
  input wire logic i_probe_present,
  input wire logic [smc_pkg::PROBE_ID_W-1:0] i_probe_id,
  input wire logic i_freeze_req,
  input wire logic i_frozen,
  input wire logic [smc_pkg::CFG_W-1:0] i_config_sw,
  // Scan controller side of the flag.
  input wire logic i_scan_flag_set,
  input wire logic i_scan_flag_clr,
  output logic o_scan_flag,
  // Curve readout.
  input wire logic i_trig,
  input wire logic i_motion_mode,
  output logic [smc_pkg::CURVE_DW-1:0] o_gain_code,
  output logic [smc_pkg::CURVE_DW-1:0] o_filter_code,
  output logic o_curve_busy,
  // Camera, indicators and relay.
  input wire logic i_vsync,
  output logic o_monitor_switch,
  output logic o_print_shutter,
  output logic o_shutter_relay,
  output logic [smc_pkg::LED_W-1:0] o_leds
);
  if (RTC_DIV < 2 || RTC_DIV > 65536 || SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 256)
  begin : g_param_check
    $error("smc_master_dev: parameter out of range");
  end

  function automatic logic [2:0] prio_enc(input logic [7:0] p);
    logic [2:0] v;
    v = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (p[i])
      begin
        v = 3'(i);
      end
    end
    return v;
  endfunction

  logic cmd_wr;
  logic cmd_rd;
  logic curve_wr;
  logic curve_rd;
  assign cmd_wr = bus.cmd_valid && (bus.cmd_op == smc_pkg::OP_CURVE_WR);
  assign cmd_rd = bus.cmd_valid && (bus.cmd_op == smc_pkg::OP_CURVE_RD);
  assign curve_wr = cmd_wr && i_frozen; // R09
  assign curve_rd = cmd_rd && i_frozen; // R11

  // Interval timer divider and interrupt event detection.
  logic [15:0] rtc_cnt_q;
  logic timer_evt_q;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      rtc_cnt_q <= 16'h0000;
      timer_evt_q <= 1'b0;
    end
    else
    begin
      timer_evt_q <= 1'b0;
      if (i_rtc_tick)
      begin
        if (rtc_cnt_q == 16'(RTC_DIV - 1))
        begin
          rtc_cnt_q <= 16'h0000;
          timer_evt_q <= 1'b1; // R20
        end
        else
        begin
          rtc_cnt_q <= rtc_cnt_q + 16'h0001;
        end
      end
    end
  end

  logic foot_q;
  logic keyb_q;
  logic probe_q;
  logic freeze_q;
  logic [smc_pkg::TRACK_W-1:0] track_q;
  logic [7:0] evt;
  // Edge history follows the pins through reset, so a level held across reset raises no interrupt.
  always_ff @(posedge i_core_clk)
  begin
    foot_q <= i_footswitch;
    keyb_q <= i_keyboard;
    probe_q <= i_probe_present;
    freeze_q <= i_freeze_req;
    track_q <= i_trackball;
  end

  always_comb
  begin
    evt = 8'h00;
    evt[smc_pkg::IRQ_TIMER] = timer_evt_q;
    evt[smc_pkg::IRQ_FOOT] = i_footswitch && !foot_q;
    evt[smc_pkg::IRQ_KEYB] = i_keyboard && !keyb_q;
    evt[smc_pkg::IRQ_PROBE_OPEN] = !i_probe_present && probe_q; // R03
    evt[smc_pkg::IRQ_PROBE_CLOSE] = i_probe_present && !probe_q; // R03
    evt[smc_pkg::IRQ_TRACK] = |(i_trackball & ~track_q); // R02
    evt[smc_pkg::IRQ_FREEZE] = i_freeze_req && !freeze_q;
  end

  logic [7:0] pend_q;
  logic [7:0] ack_mask;
  logic [2:0] vec_d1_q;
  logic [2:0] vec_d2_q;
  // The acknowledge names the vector the controller showed, two cycles older than the current one.
  // Clearing that one keeps a newer, higher line from being dropped unseen.
  assign ack_mask = bus.irq_ack ? (8'h01 << vec_d2_q) : 8'h00;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      pend_q <= 8'h00;
      vec_d1_q <= 3'h0;
      vec_d2_q <= 3'h0;
      bus.irq <= 1'b0;
      bus.irq_vec <= 3'h0;
    end
    else
    begin
      vec_d1_q <= bus.irq_vec;
      vec_d2_q <= vec_d1_q;
      pend_q <= (pend_q & ~ack_mask) | evt;
      bus.irq <= |((pend_q & ~ack_mask) | evt);
      bus.irq_vec <= prio_enc((pend_q & ~ack_mask) | evt); // R01
    end
  end

  // Processor-to-processor flag; a set in the same cycle as a clear wins.
  logic flag_set;
  logic flag_clr;
  assign flag_set = i_scan_flag_set || (bus.cmd_valid && bus.cmd_op == smc_pkg::OP_FLAG_SET);
  assign flag_clr = i_scan_flag_clr || (bus.cmd_valid && bus.cmd_op == smc_pkg::OP_FLAG_CLR);
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      bus.flag <= 1'b0;
      o_scan_flag <= 1'b0;
    end
    else
    begin
      bus.flag <= flag_set || (bus.flag && !flag_clr); // R04
      o_scan_flag <= flag_set || (bus.flag && !flag_clr); // R04
    end
  end

  // Curve buffer with a single port shared by the range counter and the controller.
  logic [smc_pkg::CURVE_DW-1:0] curve_mem [0:smc_pkg::CURVE_DEPTH-1]; // R05
  logic [smc_pkg::CURVE_DW-1:0] mem_q;
  logic [smc_pkg::CURVE_AW-1:0] ro_addr;
  logic [smc_pkg::CURVE_AW-1:0] mem_addr;
  logic ro_active_q;
  logic [7:0] ro_idx_q;
  logic [7:0] pace_q;
  logic ro_motion_q;
  logic ro_step;
  logic ro_vld_q;
  logic ro_sel_q;
  assign ro_step = ro_active_q && (pace_q == 8'(SAMPLE_CYCLES - 1));
  always_comb
  begin
    ro_addr = '0;
    ro_addr[smc_pkg::ADDR_SEL_POS] = ro_idx_q[0]; // R07
    ro_addr[smc_pkg::ADDR_PT_POS +: 7] = ro_idx_q[7:1];
    ro_addr[smc_pkg::ADDR_MOTION_POS] = ro_motion_q; // R10
  end
  assign mem_addr = i_frozen ? bus.cmd_addr : ro_addr; // R08

  always_ff @(posedge i_core_clk)
  begin
    if (curve_wr)
    begin
      curve_mem[mem_addr] <= bus.cmd_data;
    end
    mem_q <= curve_mem[mem_addr]; // R13
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b || i_frozen)
    begin
      ro_active_q <= 1'b0;
      ro_idx_q <= 8'h00;
      pace_q <= 8'h00;
      ro_motion_q <= 1'b0;
    end
    else if (i_trig)
    begin
      ro_active_q <= 1'b1; // R08
      ro_idx_q <= 8'h00;
      pace_q <= 8'h00;
      ro_motion_q <= i_motion_mode; // R10
    end
    else if (ro_active_q)
    begin
      pace_q <= ro_step ? 8'h00 : pace_q + 8'h01;
      if (ro_step)
      begin
        ro_idx_q <= ro_idx_q + 8'h01;
        if (ro_idx_q == 8'(2 * smc_pkg::CURVE_POINTS - 1))
        begin
          ro_active_q <= 1'b0; // R06
        end
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      ro_vld_q <= 1'b0;
      ro_sel_q <= 1'b0;
      o_gain_code <= '0;
      o_filter_code <= '0;
      o_curve_busy <= 1'b0;
    end
    else
    begin
      ro_vld_q <= ro_step && !i_frozen;
      ro_sel_q <= ro_idx_q[0];
      o_curve_busy <= ro_active_q;
      if (ro_vld_q && !ro_sel_q)
      begin
        o_gain_code <= mem_q; // R19
      end
      if (ro_vld_q && ro_sel_q)
      begin
        o_filter_code <= mem_q; // R19
      end
    end
  end

  // Controller answers one cycle after each command, two cycles after a buffer read while frozen.
  logic rd_pend_q;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      rd_pend_q <= 1'b0;
      bus.rsp_valid <= 1'b0;
      bus.rsp_err <= 1'b0;
      bus.rsp_data <= 8'h00;
      bus.frozen <= 1'b0;
    end
    else
    begin
      bus.frozen <= i_frozen;
      rd_pend_q <= 1'b0;
      bus.rsp_valid <= bus.cmd_valid;
      bus.rsp_err <= (cmd_wr || cmd_rd) && !i_frozen; // R09
      bus.rsp_data <= 8'h00;
      case (bus.cmd_op)
        smc_pkg::OP_FLAG_SET, smc_pkg::OP_FLAG_CLR: bus.rsp_data <= {7'h00, bus.flag};
        smc_pkg::OP_CFG_RD: bus.rsp_data <= i_config_sw; // R17
        smc_pkg::OP_PROBE_RD: bus.rsp_data <= 8'(i_probe_id); // R03
        default: bus.rsp_data <= 8'h00;
      endcase
      if (curve_rd)
      begin
        bus.rsp_valid <= 1'b0;
        rd_pend_q <= 1'b1;
      end
      if (rd_pend_q)
      begin
        bus.rsp_valid <= 1'b1;
        bus.rsp_err <= 1'b0;
        bus.rsp_data <= mem_q; // R11
      end
    end
  end

  // Frame counter for camera monitor switching and print shutter.
  logic [smc_pkg::FRAME_W-1:0] frames_q;
  logic armed_q;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      frames_q <= '0;
      armed_q <= 1'b0;
      o_monitor_switch <= 1'b0;
      o_print_shutter <= 1'b0;
    end
    else if (bus.cmd_valid && bus.cmd_op == smc_pkg::OP_FRAMES)
    begin
      frames_q <= bus.cmd_data; // R14
      armed_q <= bus.cmd_data != 8'h00;
      o_monitor_switch <= 1'b0;
      o_print_shutter <= 1'b0;
    end
    else if (i_vsync && armed_q)
    begin
      if (!o_monitor_switch)
      begin
        o_monitor_switch <= 1'b1; // R15
        o_print_shutter <= 1'b1; // R15
      end
      else if (frames_q == 8'h01)
      begin
        frames_q <= 8'h00;
        armed_q <= 1'b0;
        o_monitor_switch <= 1'b0; // R15
        o_print_shutter <= 1'b0;
      end
      else
      begin
        frames_q <= frames_q - 8'h01; // R14
      end
    end
  end

  // Indicators and shutter relay.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      o_leds <= '0;
      o_shutter_relay <= 1'b0;
    end
    else if (bus.cmd_valid)
    begin
      if (bus.cmd_op == smc_pkg::OP_KICK)
      begin
        o_leds[0] <= !o_leds[0]; // R16
      end
      if (bus.cmd_op == smc_pkg::OP_LEDS)
      begin
        o_leds[7:1] <= bus.cmd_data[7:1]; // R16
      end
      if (bus.cmd_op == smc_pkg::OP_RELAY)
      begin
        o_shutter_relay <= bus.cmd_data[0]; // R18
      end
    end
  end
endmodule

/* File: rtl/smc_sys_ctrl.sv */
`timescale 1ns/1ps
module smc_sys_ctrl (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Device side.
  smc_if.host bus,
  // Request from controller software.
  input wire logic i_req_valid,
  input wire smc_pkg::smc_op_t i_req_op,
  input wire logic [10:0] i_req_addr,
  input wire logic [7:0] i_req_data,
  output logic o_req_ready,
  // Answer to software.
  output logic o_rsp_valid,
  output logic o_rsp_err,
  output logic [7:0] o_rsp_data,
  // Interrupt hand-off.
  input wire logic i_irq_take,
  output logic o_irq_valid,
  output logic [2:0] o_irq_vec,
  output logic o_flag,
  output logic o_frozen
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } smc_host_st_t;
  smc_host_st_t st_q;
  logic refuse;
  // Curve writes are held back outside freeze; a flag set is held back while the flag is up.
  assign refuse = ((i_req_op == smc_pkg::OP_CURVE_WR) && !bus.frozen) // R09
    || ((i_req_op == smc_pkg::OP_FLAG_SET) && bus.flag); // R04

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      st_q <= ST_IDLE;
      bus.cmd_valid <= 1'b0;
      bus.cmd_op <= smc_pkg::OP_CFG_RD;
      bus.cmd_addr <= '0;
      bus.cmd_data <= '0;
      o_req_ready <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_err <= 1'b0;
      o_rsp_data <= 8'h00;
    end
    else
    begin
      bus.cmd_valid <= 1'b0;
      o_rsp_valid <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          o_req_ready <= 1'b1;
          if (i_req_valid && o_req_ready)
          begin
            o_req_ready <= 1'b0;
            if (refuse)
            begin
              o_rsp_valid <= 1'b1;
              o_rsp_err <= 1'b1;
              o_rsp_data <= 8'h00;
            end
            else
            begin
              bus.cmd_valid <= 1'b1;
              bus.cmd_op <= i_req_op;
              bus.cmd_addr <= i_req_addr;
              bus.cmd_data <= i_req_data;
              st_q <= ST_WAIT;
            end
          end
        end
        ST_WAIT:
        begin
          if (bus.rsp_valid)
          begin
            o_rsp_valid <= 1'b1;
            o_rsp_err <= bus.rsp_err;
            o_rsp_data <= bus.rsp_data;
            o_req_ready <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Interrupt acknowledge: one pulse per accepted vector, then wait for the device to update.
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      bus.irq_ack <= 1'b0;
      o_irq_valid <= 1'b0;
      o_irq_vec <= 3'h0;
      o_flag <= 1'b0;
      o_frozen <= 1'b0;
    end
    else
    begin
      o_flag <= bus.flag;
      o_frozen <= bus.frozen;
      bus.irq_ack <= 1'b0;
      o_irq_valid <= bus.irq && !bus.irq_ack && !(i_irq_take && o_irq_valid);
      o_irq_vec <= bus.irq_vec;
      if (i_irq_take && o_irq_valid)
      begin
        bus.irq_ack <= 1'b1; // R12
      end
    end
  end
endmodule

/* File: bench/smc_chk_sva.sv */
`timescale 1ns/1ps
module smc_chk_sva (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Command and answer path.
  input wire logic cmd_valid,
  input wire smc_pkg::smc_op_t cmd_op,
  input wire logic [10:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [7:0] rsp_data,
  // Interrupt, flag and freeze state.
  input wire logic irq,
  input wire logic [2:0] irq_vec,
  input wire logic irq_ack,
  input wire logic flag,
  input wire logic frozen
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  property p_rsp_next;
    cmd_valid && cmd_op != smc_pkg::OP_CURVE_RD |=> rsp_valid;
  endproperty
  a_rsp_next: assert property (p_rsp_next) else $error("command not answered next cycle");
  property p_rd_answer;
    cmd_valid && cmd_op == smc_pkg::OP_CURVE_RD |-> ##[1:2] rsp_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("buffer read not answered");
  property p_wr_gate;
    cmd_valid && cmd_op == smc_pkg::OP_CURVE_WR |=> rsp_valid && (rsp_err == !frozen);
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("buffer write gating wrong");
  property p_flag_set;
    cmd_valid && cmd_op == smc_pkg::OP_FLAG_SET |=> flag && !rsp_err;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set by command");
  property p_rsp_pulse;
    rsp_valid |=> !rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer longer than one cycle");
  property p_cmd_gap;
    cmd_valid |=> !cmd_valid [*2];
  endproperty
  a_cmd_gap: assert property (p_cmd_gap) else $error("command sent while one outstanding");
  property p_irq_hold;
    irq && !irq_ack |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("pending interrupt lost");
  property p_irq_prio;
    irq && !irq_ack |=> irq_vec <= $past(irq_vec);
  endproperty
  a_irq_prio: assert property (p_irq_prio) else $error("lower priority line shown first");
  property p_ack_shown;
    irq_ack |-> $past(irq);
  endproperty
  a_ack_shown: assert property (p_ack_shown) else $error("acknowledge with nothing pending");
  c_wr: cover property (cmd_valid && cmd_op == smc_pkg::OP_CURVE_WR ##1 rsp_valid && !rsp_err);
  c_rd: cover property (cmd_valid && cmd_op == smc_pkg::OP_CURVE_RD ##2 rsp_valid);
  c_ack: cover property (irq_ack ##1 irq);
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; $display("[ERR] %0t %0h %0h", $time, (a), (e)); end end
module tb_top;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_rtc_tick, i_footswitch, i_keyboard, i_probe_present, i_freeze_req, i_frozen, i_trig;
  logic i_scan_flag_set, i_scan_flag_clr, i_motion_mode, i_vsync, i_req_valid, i_irq_take;
  logic [3:0] i_trackball, i_probe_id;
  logic [7:0] i_config_sw, i_req_data, o_gain_code, o_filter_code, o_leds, o_rsp_data, key, rd, n;
  logic [10:0] i_req_addr;
  smc_pkg::smc_op_t i_req_op;
  logic o_scan_flag, o_curve_busy, o_monitor_switch, o_print_shutter, o_shutter_relay, er;
  logic o_req_ready, o_rsp_valid, o_rsp_err, o_irq_valid, o_flag, o_frozen;
  logic [2:0] o_irq_vec;
  logic [31:0] seed = 32'h4034;
  logic [2:0] exp_v [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int bc;
  always #20 i_core_clk = ~i_core_clk;
  smc_if smc_if_inst ();
  smc_master_dev #(.RTC_DIV(4), .SAMPLE_CYCLES(1)) smc_master_dev_inst (.i_core_clk, .i_rst_b,
    .bus(smc_if_inst), .i_rtc_tick, .i_footswitch, .i_keyboard, .i_trackball, .i_probe_present,
    .i_probe_id, .i_freeze_req, .i_frozen, .i_config_sw, .i_scan_flag_set, .i_scan_flag_clr,
    .o_scan_flag, .i_trig, .i_motion_mode, .o_gain_code, .o_filter_code, .o_curve_busy, .i_vsync,
    .o_monitor_switch, .o_print_shutter, .o_shutter_relay, .o_leds);
  smc_sys_ctrl smc_sys_ctrl_inst (.i_core_clk, .i_rst_b, .bus(smc_if_inst), .i_req_valid, .i_req_op,
    .i_req_addr, .i_req_data, .o_req_ready, .o_rsp_valid, .o_rsp_err, .o_rsp_data, .i_irq_take,
    .o_irq_valid, .o_irq_vec, .o_flag, .o_frozen);
  smc_chk_sva smc_chk_sva_inst (.i_core_clk, .i_rst_b, .cmd_valid(smc_if_inst.cmd_valid),
    .cmd_op(smc_if_inst.cmd_op), .cmd_addr(smc_if_inst.cmd_addr), .cmd_data(smc_if_inst.cmd_data),
    .rsp_valid(smc_if_inst.rsp_valid), .rsp_err(smc_if_inst.rsp_err), .rsp_data(smc_if_inst.rsp_data),
    .irq(smc_if_inst.irq), .irq_vec(smc_if_inst.irq_vec), .irq_ack(smc_if_inst.irq_ack),
    .flag(smc_if_inst.flag), .frozen(smc_if_inst.frozen));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Curve contents: gain at even, filter at odd addresses, motion set flipped in bit 7.
  function automatic logic [7:0] cval(input logic [10:0] a);
    return a[7:0] ^ key ^ {a[8], 7'h00};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end
  // Drives one request at a falling edge once ready is up and waits for its answer.
  task automatic req(input smc_pkg::smc_op_t op, input logic [10:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(negedge i_core_clk);
    while (o_req_ready !== 1'b1 && k < 50)
    begin
      @(negedge i_core_clk);
      k++;
    end
    i_req_valid = 1'b1;
    i_req_op = op;
    i_req_addr = a;
    i_req_data = d;
    @(negedge i_core_clk);
    i_req_valid = 1'b0;
    while (o_rsp_valid !== 1'b1 && k < 100)
    begin
      @(negedge i_core_clk);
      k++;
    end
    if (o_rsp_valid !== 1'b1)
    begin
      n_fail++;
    end
    rd = o_rsp_data;
    er = o_rsp_err;
  endtask
  task automatic take(input logic [2:0] v);
    int k;
    k = 0;
    while (o_irq_valid !== 1'b1 && k < 50)
    begin
      @(negedge i_core_clk);
      k++;
    end
    if (o_irq_valid !== 1'b1)
    begin
      n_fail++;
    end
    `CHK(o_irq_vec, v)
    i_irq_take = 1'b1;
    @(negedge i_core_clk);
    i_irq_take = 1'b0;
    repeat (3) @(negedge i_core_clk);
  endtask
  initial
  begin
    {i_rtc_tick, i_footswitch, i_keyboard, i_probe_present, i_freeze_req, i_frozen, i_trig} = '0;
    {i_scan_flag_set, i_scan_flag_clr, i_motion_mode, i_vsync, i_req_valid, i_irq_take} = '0;
    {i_trackball, i_probe_id, i_config_sw, i_req_data, i_req_addr} = '0;
    i_req_op = smc_pkg::OP_CFG_RD;
    repeat (20) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    seed = lfsr(seed);
    i_config_sw = seed[7:0];
    i_probe_id = seed[11:8];
    key = seed[23:16];
    req(smc_pkg::OP_CFG_RD, 11'h000, 8'h00);
    `CHK(rd, i_config_sw)
    req(smc_pkg::OP_PROBE_RD, 11'h000, 8'h00);
    `CHK(rd[3:0], i_probe_id)
    req(smc_pkg::OP_CURVE_WR, 11'h7FF, 8'h00);
    `CHK(er, 1'b1)
    i_frozen = 1'b1;
    repeat (2) @(negedge i_core_clk);
    `CHK(smc_if_inst.frozen, 1'b1)
    `CHK(o_frozen, 1'b1)
    for (int a = 0; a < 512; a++)
      req(smc_pkg::OP_CURVE_WR, a[10:0], cval(a[10:0]));
    req(smc_pkg::OP_CURVE_WR, 11'h7FF, 8'hFF);
    `CHK(er, 1'b0)
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      req(smc_pkg::OP_CURVE_RD, {2'h0, seed[8:0]}, 8'h00);
      `CHK(rd, cval({2'h0, seed[8:0]}))
    end
    req(smc_pkg::OP_CURVE_RD, 11'h7FF, 8'h00);
    `CHK(rd, 8'hFF)
    req(smc_pkg::OP_CURVE_WR, 11'h7FE, 8'h00);
    req(smc_pkg::OP_CURVE_RD, 11'h7FE, 8'h00);
    `CHK(rd, 8'h00)
    i_frozen = 1'b0;
    req(smc_pkg::OP_CURVE_WR, 11'h000, ~cval(11'h000));
    `CHK(er, 1'b1)
    req(smc_pkg::OP_CURVE_RD, 11'h000, 8'h00);
    `CHK(er, 1'b1)
    for (int m = 0; m < 2; m++)
    begin
      i_motion_mode = m[0];
      i_trig = 1'b1;
      @(negedge i_core_clk);
      i_trig = 1'b0;
      bc = 0;
      while (o_curve_busy !== 1'b1 && bc < 10)
      begin
        @(negedge i_core_clk);
        bc++;
      end
      bc = 0;
      while (o_curve_busy === 1'b1 && bc < 2000)
      begin
        @(negedge i_core_clk);
        bc++;
      end
      repeat (4) @(negedge i_core_clk);
      `CHK(o_gain_code, cval({2'h0, m[0], 8'hFE}))
      `CHK(o_filter_code, cval({2'h0, m[0], 8'hFF}))
      `CHK(bc >= 256 && bc < 300, 1'b1)
    end
    i_frozen = 1'b1;
    req(smc_pkg::OP_CURVE_RD, 11'h000, 8'h00);
    `CHK(rd, cval(11'h000))
    req(smc_pkg::OP_FLAG_SET, 11'h000, 8'h00);
    `CHK({er, o_flag, o_scan_flag, smc_if_inst.flag}, 4'h7)
    req(smc_pkg::OP_FLAG_SET, 11'h000, 8'h00);
    `CHK(er, 1'b1)
    i_scan_flag_clr = 1'b1;
    @(negedge i_core_clk);
    i_scan_flag_clr = 1'b0;
    repeat (3) @(negedge i_core_clk);
    `CHK({o_flag, o_scan_flag}, 2'h0)
    i_scan_flag_set = 1'b1;
    @(negedge i_core_clk);
    i_scan_flag_set = 1'b0;
    req(smc_pkg::OP_FLAG_CLR, 11'h000, 8'h00);
    `CHK({rd[0], o_flag, o_scan_flag}, 3'h4)
    seed = lfsr(seed);
    req(smc_pkg::OP_LEDS, 11'h000, seed[7:0]);
    `CHK(o_leds, {seed[7:1], 1'b0})
    req(smc_pkg::OP_KICK, 11'h000, 8'h00);
    `CHK(o_leds[0], 1'b1)
    req(smc_pkg::OP_RELAY, 11'h000, 8'h01);
    `CHK(o_shutter_relay, 1'b1)
    req(smc_pkg::OP_RELAY, 11'h000, 8'hFE);
    `CHK(o_shutter_relay, 1'b0)
    n = {6'h00, seed[9:8]} + 8'h01;
    req(smc_pkg::OP_FRAMES, 11'h000, n);
    for (int k = 1; k <= 5; k++)
    begin
      i_vsync = 1'b1;
      @(negedge i_core_clk);
      i_vsync = 1'b0;
      repeat (3) @(negedge i_core_clk);
      `CHK({o_monitor_switch, o_print_shutter}, {2{k <= n}})
    end
    repeat (4)
    begin
      i_rtc_tick = 1'b1;
      @(negedge i_core_clk);
      i_rtc_tick = 1'b0;
      @(negedge i_core_clk);
    end
    {i_footswitch, i_keyboard, i_probe_present, i_freeze_req} = 4'hF;
    i_trackball = 4'h1 << seed[13:12];
    for (int i = 0; i < 6; i++)
      take(exp_v[i]);
    i_probe_present = 1'b0;
    take(3'h3);
    `CHK(smc_if_inst.irq, 1'b0)
    stop_test();
  end
endmodule
